// file: hdl/vlan_egress_qualification.sv
// VLAN egress qualification: turns one switch request into the set of egress ports allowed to send it.
// Assumes requests and config accesses are synchronous to clk_sys and that headers arrive already parsed.
//
// Function
// - In port-based mode the egress set comes from the ingress port's map, but a tagged frame still reports its own VLAN ID.
// - Each ingress port keeps a ten-bit egress map, ports 0-7 in its low register and 8-9 in its high one.
// - In port mode a map bit of 1 makes that egress port eligible and a bit of 0 makes it ineligible.
// - Each decision yields either the eligible egress set or a discard indication when it is empty.
// - In tag-based mode the 4-octet tag after the source address is recognised and its 12-bit VLAN ID used.
// - Up to 4 K VLANs are held, and in tag mode each learned address is reported with its VLAN.
// - Tagged traffic leaves with the incoming tag replaced by the forwarding tag.
// - A provider tag placed just ahead of the customer tag is recognised in stacked frames.
// - A single switch-wide configurable TPID identifies provider tags.
// - A provider TPID equal to 0x8100 is never treated as a provider tag.
// - Traffic of any kind is never forwarded from one protected port to another.
// - Isolation covers only the ports of this switch, nothing on another switch.
// - Each fast port has its own private domain setting, applied as the last egress check.
// - In tag mode a unicast to a member port goes only there, otherwise to every VLAN member.
// - In port mode the egress maps change only by configuration writes.
`timescale 1ns/1ps
module vlan_egress_qualification
   import vlan_egress_pkg::*;
#(
   parameter int NUM_PORTS = 10
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [CFG_ADDR_W-1:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic req_valid,
   input wire logic [PORT_W-1:0] req_port,
   input wire logic req_unicast,
   input wire logic req_dest_known,
   input wire logic [PORT_W-1:0] req_dest_port,
   input wire logic [15:0] req_type_outer,
   input wire logic [15:0] req_tci_outer,
   input wire logic [15:0] req_type_inner,
   input wire logic [15:0] req_tci_inner,
   output logic resp_valid,
   output logic [NUM_PORTS-1:0] resp_ports,
   output logic resp_discard,
   output logic [VID_W-1:0] resp_vid,
   output logic resp_vid_learn,
   output logic [15:0] resp_fwd_tci,
   output logic resp_stacked
);

   // ==========================================================================
   // Elaboration check
   // The high map register holds up to eight more ports, and the port number must fit its field.
   if (NUM_PORTS < FAST_PORTS + 1 || NUM_PORTS > 16 || NUM_PORTS > (1 << PORT_W)) begin : g_bad_ports
      $error("NUM_PORTS must lie between 9 and 16");
   end

   // ==========================================================================
   // Configuration state
   logic [NUM_PORTS-1:0] egress_map [NUM_PORTS];
   logic [VID_W-1:0] port_vid [NUM_PORTS];
   logic [7:0] mode;
   logic [FAST_PORTS-1:0] private_domain;
   logic [15:0] provider_tpid;
   logic [VID_W-1:0] vlan_sel;
   logic [NUM_PORTS-1:0] vlan_stage;
   logic [NUM_PORTS-1:0] vlan_mem [VLAN_COUNT];
   logic [VLAN_COUNT-1:0] vlan_valid;
   logic [7:0] discard_count;
   logic tag_mode;
   logic vlan_commit;

   assign tag_mode = mode[MODE_TAG_BIT];
   assign vlan_commit = cfg_wr && cfg_addr == VLAN_MEMBER_HIGH;

   // Egress maps reset open to all other ports and default VLANs to 1, so a fresh switch forwards.
   // Configuration only
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            egress_map[p] <= ~(NUM_PORTS'(1) << p);
            port_vid[p] <= PORT_VID_RESET;
         end
      end else if (cfg_wr) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (cfg_addr == EGRESS_MAP_BASE + 8'(2 * p)) begin
               egress_map[p][FAST_PORTS-1:0] <= cfg_wdata;
            end
            if (cfg_addr == EGRESS_MAP_BASE + 8'(2 * p + 1)) begin
               egress_map[p][NUM_PORTS-1:FAST_PORTS] <= cfg_wdata[NUM_PORTS-FAST_PORTS-1:0];
            end
            if (cfg_addr == PORT_VID_BASE + 8'(2 * p)) begin
               port_vid[p][7:0] <= cfg_wdata;
            end
            if (cfg_addr == PORT_VID_BASE + 8'(2 * p + 1)) begin
               port_vid[p][VID_W-1:8] <= cfg_wdata[VID_W-9:0];
            end
         end
      end
   end

   // Switch-wide settings.
   // Global provider TPID
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode <= MODE_RESET;
         private_domain <= PRIVATE_DOMAIN_RESET;
         provider_tpid <= PROVIDER_TPID_RESET;
         vlan_sel <= '0;
         vlan_stage <= '0;
      end else if (cfg_wr) begin
         case (cfg_addr)
            MODE_REG: mode <= cfg_wdata;
            PRIVATE_DOMAIN_REG: private_domain <= cfg_wdata;
            PROVIDER_TPID_LOW: provider_tpid[7:0] <= cfg_wdata;
            PROVIDER_TPID_HIGH: provider_tpid[15:8] <= cfg_wdata;
            VLAN_SEL_LOW: vlan_sel[7:0] <= cfg_wdata;
            VLAN_SEL_HIGH: vlan_sel[VID_W-1:8] <= cfg_wdata[VID_W-9:0];
            VLAN_MEMBER_LOW: vlan_stage[FAST_PORTS-1:0] <= cfg_wdata;
            VLAN_MEMBER_HIGH: vlan_stage[NUM_PORTS-1:FAST_PORTS] <= cfg_wdata[NUM_PORTS-FAST_PORTS-1:0];
            default: ;
         endcase
      end
   end

   // VLAN membership table. The array has no reset, so a valid bit per entry hides stale contents.
   // Four thousand VLANs
   always_ff @(posedge clk_sys) begin
      if (vlan_commit) begin
         vlan_mem[vlan_sel] <= {cfg_wdata[NUM_PORTS-FAST_PORTS-1:0], vlan_stage[FAST_PORTS-1:0]};
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         vlan_valid <= '0;
      end else if (vlan_commit) begin
         vlan_valid[vlan_sel] <= 1'b1;
      end
   end

   // ==========================================================================
   // Config read port, one cycle of latency; unmapped indices read zero.
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (cfg_addr == EGRESS_MAP_BASE + 8'(2 * p)) begin
            next_rdata = egress_map[p][FAST_PORTS-1:0];
         end
         if (cfg_addr == EGRESS_MAP_BASE + 8'(2 * p + 1)) begin
            next_rdata = 8'(egress_map[p][NUM_PORTS-1:FAST_PORTS]);
         end
         if (cfg_addr == PORT_VID_BASE + 8'(2 * p)) begin
            next_rdata = port_vid[p][7:0];
         end
         if (cfg_addr == PORT_VID_BASE + 8'(2 * p + 1)) begin
            next_rdata = 8'(port_vid[p][VID_W-1:8]);
         end
      end
      case (cfg_addr)
         MODE_REG: next_rdata = mode;
         PRIVATE_DOMAIN_REG: next_rdata = private_domain;
         PROVIDER_TPID_LOW: next_rdata = provider_tpid[7:0];
         PROVIDER_TPID_HIGH: next_rdata = provider_tpid[15:8];
         VLAN_SEL_LOW: next_rdata = vlan_sel[7:0];
         VLAN_SEL_HIGH: next_rdata = 8'(vlan_sel[VID_W-1:8]);
         VLAN_MEMBER_LOW: next_rdata = vlan_stage[FAST_PORTS-1:0];
         VLAN_MEMBER_HIGH: next_rdata = 8'(vlan_stage[NUM_PORTS-1:FAST_PORTS]);
         DISCARD_COUNT_REG: next_rdata = discard_count;
         default: ;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cfg_rdata <= 8'h00;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rvalid <= cfg_rd;
         if (cfg_rd) begin
            cfg_rdata <= next_rdata;
         end
      end
   end

   // ==========================================================================
   // Stage 1: classify the tag and read the membership table.
   tag_kind_t next_kind;
   logic [VID_W-1:0] next_vid;
   logic [2:0] next_pcp;
   logic provider_ok;

   // A provider TPID equal to the customer one is never accepted, since it would alias plain tags.
   assign provider_ok = provider_tpid != CUSTOMER_TPID;

   always_comb begin
      next_kind = TAG_NONE;
      next_vid = port_vid[req_port];
      next_pcp = 3'h0;
      if (provider_ok && req_type_outer == provider_tpid && req_type_inner == CUSTOMER_TPID) begin
         next_kind = TAG_STACKED;
         next_vid = req_tci_inner[VID_W-1:0];
         next_pcp = req_tci_inner[15:PCP_LSB];
      end else if (req_type_outer == CUSTOMER_TPID) begin
         next_kind = TAG_CUSTOMER;
         next_vid = req_tci_outer[VID_W-1:0];
         next_pcp = req_tci_outer[15:PCP_LSB];
      end
   end

   logic s1_valid;
   logic s1_tag_mode;
   logic [PORT_W-1:0] s1_port;
   logic s1_unicast;
   logic s1_known;
   logic [PORT_W-1:0] s1_dest;
   tag_kind_t s1_kind;
   logic [VID_W-1:0] s1_vid;
   logic [2:0] s1_pcp;
   logic [NUM_PORTS-1:0] s1_members;
   logic [NUM_PORTS-1:0] s1_map;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s1_valid <= 1'b0;
         s1_tag_mode <= 1'b0;
         s1_port <= '0;
         s1_unicast <= 1'b0;
         s1_known <= 1'b0;
         s1_dest <= '0;
         s1_kind <= TAG_NONE;
         s1_vid <= '0;
         s1_pcp <= 3'h0;
         s1_members <= '0;
         s1_map <= '0;
      end else begin
         s1_valid <= req_valid;
         if (req_valid) begin
            s1_tag_mode <= tag_mode;
            s1_port <= req_port;
            s1_unicast <= req_unicast;
            s1_known <= req_dest_known && {1'b0, req_dest_port} < (PORT_W + 1)'(NUM_PORTS);
            s1_dest <= req_dest_port;
            s1_kind <= next_kind;
            s1_vid <= next_vid;
            s1_pcp <= next_pcp;
            s1_members <= vlan_valid[next_vid] ? vlan_mem[next_vid] : '0;
            s1_map <= egress_map[req_port];
         end
      end
   end

   // ==========================================================================
   // Stage 2: choose the VLAN set, then apply the private domain.
   logic [NUM_PORTS-1:0] vlan_set;
   logic [NUM_PORTS-1:0] domain_reject;
   logic [NUM_PORTS-1:0] next_ports;
   logic [NUM_PORTS-1:0] dest_onehot;
   logic src_protected;

   assign dest_onehot = NUM_PORTS'(1) << s1_dest;
   assign src_protected = s1_port < PORT_W'(FAST_PORTS) && private_domain[s1_port[2:0]];

   always_comb begin
      if (s1_tag_mode) begin
         if (s1_unicast && s1_known && s1_members[s1_dest]) begin
            vlan_set = dest_onehot;
         end else begin
            vlan_set = s1_members;
         end
      end else if (s1_unicast && s1_known) begin
         vlan_set = s1_map & dest_onehot;
      end else begin
         vlan_set = s1_map;
      end
   end

   // Only fast ports can be protected; the gigabit ports are never rejected here.
   // Protected to protected
   genvar g;
   for (g = 0; g < NUM_PORTS; g++) begin : g_domain
      if (g < FAST_PORTS) begin : g_fast
         assign domain_reject[g] = src_protected && private_domain[g];
      end else begin : g_other
         assign domain_reject[g] = 1'b0;
      end
   end

   assign next_ports = vlan_set & ~domain_reject;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         resp_valid <= 1'b0;
         resp_ports <= '0;
         resp_discard <= 1'b0;
         resp_vid <= '0;
         resp_vid_learn <= 1'b0;
         resp_fwd_tci <= 16'h0000;
         resp_stacked <= 1'b0;
      end else begin
         resp_valid <= s1_valid;
         if (s1_valid) begin
            resp_ports <= next_ports;
            resp_discard <= next_ports == '0;
            resp_vid <= s1_vid;
            resp_vid_learn <= s1_tag_mode;
            resp_fwd_tci <= {s1_pcp, 1'b0, s1_vid};
            resp_stacked <= s1_kind == TAG_STACKED;
         end
      end
   end

   // Discard counter saturates so software never sees a wrap look like a quiet link.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         discard_count <= 8'h00;
      end else if (s1_valid && next_ports == '0 && discard_count != 8'hff) begin
         discard_count <= discard_count + 8'h01;
      end
   end

   // ==========================================================================
   // Assertions
   discard_empty_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      resp_valid |-> (resp_discard == (resp_ports == '0)))
      else $error("discard flag disagrees with port set");
   answer_latency_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      req_valid |-> ##2 resp_valid)
      else $error("answer not two cycles after request");
   protected_pair_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s1_valid && src_protected |=> (resp_ports[FAST_PORTS-1:0] & $past(private_domain)) == '0)
      else $error("protected port forwarded to protected port");
   port_mode_map_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      req_valid && !tag_mode && !req_unicast |-> ##2
      resp_ports == ($past(egress_map[req_port], 2) & ~$past(domain_reject)))
      else $error("port mode result differs from map");
   unicast_single_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s1_valid && s1_tag_mode && s1_unicast && s1_known && s1_members[s1_dest] |=> $countones(resp_ports) <= 1)
      else $error("member unicast sent to more than one port");
   bad_tpid_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      req_valid && provider_tpid == CUSTOMER_TPID |-> ##2 !resp_stacked)
      else $error("0x8100 accepted as provider tag");
   stacked_vid_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      req_valid && next_kind == TAG_STACKED |-> ##2 resp_vid == $past(req_tci_inner[VID_W-1:0], 2))
      else $error("stacked frame not classified by customer tag");
   map_static_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !cfg_wr |=> egress_map[0] == $past(egress_map[0]))
      else $error("egress map changed without a write");
   fwd_tag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      resp_valid |-> resp_fwd_tci[VID_W-1:0] == resp_vid)
      else $error("forwarding tag does not carry the VLAN");

endmodule

// file: include/vlan_egress_pkg.sv
// Constants, register offsets and types for the VLAN egress qualification block.
// Assumes a single switch core clock; every offset is a register index on the config port.
package vlan_egress_pkg;

   // ==========================================================================
   // Widths and sizes
   localparam int PORT_W = 4;
   localparam int VID_W = 12;
   localparam int VLAN_COUNT = 4096;
   localparam int FAST_PORTS = 8;
   localparam int CFG_ADDR_W = 8;

   // ==========================================================================
   // Tag protocol identifiers
   localparam logic [15:0] CUSTOMER_TPID = 16'h8100;
   localparam logic [15:0] PROVIDER_TPID_RESET = 16'h9100;

   // ==========================================================================
   // Register offsets (indices on the config port)
   localparam logic [7:0] EGRESS_MAP_BASE = 8'h00;   // Port p low at 2p, high at 2p+1.
   localparam logic [7:0] PORT_VID_BASE = 8'h20;     // Port p low at 2p, high at 2p+1.
   localparam logic [7:0] MODE_REG = 8'h40;
   localparam logic [7:0] PRIVATE_DOMAIN_REG = 8'h41;
   localparam logic [7:0] PROVIDER_TPID_LOW = 8'h42;
   localparam logic [7:0] PROVIDER_TPID_HIGH = 8'h43;
   localparam logic [7:0] VLAN_SEL_LOW = 8'h44;
   localparam logic [7:0] VLAN_SEL_HIGH = 8'h45;
   localparam logic [7:0] VLAN_MEMBER_LOW = 8'h46;
   localparam logic [7:0] VLAN_MEMBER_HIGH = 8'h47;  // A write here commits the entry.
   localparam logic [7:0] DISCARD_COUNT_REG = 8'h48;

   // ==========================================================================
   // Field positions and reset values
   localparam int MODE_TAG_BIT = 0;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] PRIVATE_DOMAIN_RESET = 8'h00;
   localparam logic [VID_W-1:0] PORT_VID_RESET = 12'h001;
   localparam int PCP_LSB = 13;
   localparam int LATENCY_CYCLES = 2;

   // Tag found at the head of the frame after the source address.
   typedef enum {TAG_NONE, TAG_CUSTOMER, TAG_STACKED} tag_kind_t;

endpackage

// file: verification/txq_sink_model.sv
// Transmit queue side model: records each switch response as the queue logic would take it.
// Assumes responses are one-cycle pulses on clk_sys and the other fields hold until the next one.
`timescale 1ns/1ps
module txq_sink_model (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic resp_valid,
   input wire logic [9:0] resp_ports,
   input wire logic resp_discard,
   input wire logic [11:0] resp_vid,
   input wire logic resp_vid_learn,
   input wire logic [15:0] resp_fwd_tci,
   input wire logic resp_stacked,
   output logic [9:0] cap_ports,
   output logic cap_discard,
   output logic [11:0] cap_vid,
   output logic cap_learn,
   output logic [15:0] cap_tci,
   output logic cap_stk
);
   // =========================================================================
   // Capture
   // Fields are taken only on the valid pulse, so a late or missing pulse shows as stale data.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {cap_ports, cap_discard, cap_vid, cap_learn, cap_tci, cap_stk} <= '0;
      end else if (resp_valid) begin
         cap_ports <= resp_ports;
         cap_discard <= resp_discard;
         cap_vid <= resp_vid;
         cap_learn <= resp_vid_learn;
         cap_tci <= resp_fwd_tci;
         cap_stk <= resp_stacked;
      end
   end
endmodule

// file: verification/test_vlan_egress_qualification.sv
// Self-checking bench for the VLAN egress qualification block.
// Assumes the transmit queue model in its own file; all stimulus goes 1 ns after the rising edge.
`timescale 1ns/1ps
module test_vlan_egress_qualification;
   import vlan_egress_pkg::*;
   logic clk_sys = 0, reset_n = 0, cfg_wr = 0, cfg_rd = 0, req_valid = 0, req_unicast = 0, req_dest_known = 0;
   logic [7:0] cfg_addr = 0, cfg_wdata = 0, cfg_rdata;
   logic cfg_rvalid, resp_valid, resp_discard, resp_vid_learn, resp_stacked, cap_discard, cap_learn, cap_stk;
   logic [3:0] req_port = 0, req_dest_port = 0;
   logic [15:0] req_type_outer = 0, req_tci_outer = 0, req_type_inner = 0, req_tci_inner = 0, resp_fwd_tci, cap_tci;
   logic [9:0] resp_ports, cap_ports;
   logic [11:0] resp_vid, cap_vid;
   logic tag_mode = 0;
   int err_total = 0, n_compared = 0;
   vlan_egress_qualification #(.NUM_PORTS(10)) vlan_egress_qualification_i (.clk_sys(clk_sys),
      .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .req_valid(req_valid), .req_port(req_port),
      .req_unicast(req_unicast), .req_dest_known(req_dest_known), .req_dest_port(req_dest_port),
      .req_type_outer(req_type_outer), .req_tci_outer(req_tci_outer), .req_type_inner(req_type_inner),
      .req_tci_inner(req_tci_inner), .resp_valid(resp_valid), .resp_ports(resp_ports),
      .resp_discard(resp_discard), .resp_vid(resp_vid), .resp_vid_learn(resp_vid_learn),
      .resp_fwd_tci(resp_fwd_tci), .resp_stacked(resp_stacked));
   txq_sink_model txq_sink_model_i (.clk_sys(clk_sys), .reset_n(reset_n), .resp_valid(resp_valid),
      .resp_ports(resp_ports), .resp_discard(resp_discard), .resp_vid(resp_vid), .resp_vid_learn(resp_vid_learn),
      .resp_fwd_tci(resp_fwd_tci), .resp_stacked(resp_stacked), .cap_ports(cap_ports), .cap_discard(cap_discard),
      .cap_vid(cap_vid), .cap_learn(cap_learn), .cap_tci(cap_tci), .cap_stk(cap_stk));

   // =========================================================================
   // Clock, verdict and shared tasks
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic summarize();
      if (err_total == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Every task starts and ends 1 ns after a rising edge.
   // An idle edge follows each access so a strobe is never lowered and raised in one time step.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cfg_wr = 1;
      cfg_addr = a;
      cfg_wdata = d;
      @(posedge clk_sys);
      #1 cfg_wr = 0;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      cfg_rd = 1;
      cfg_addr = a;
      @(posedge clk_sys);
      #1 cfg_rd = 0;
      chk(cfg_rvalid, 1);
      chk(cfg_rdata, exp);
      @(posedge clk_sys);
      #1 chk(cfg_rvalid, 0);
   endtask
   // One request; the answer is due exactly two edges after it is taken.
   task automatic req(input logic [3:0] p, input logic u, input logic k, input logic [3:0] d,
                      input logic [15:0] to, input logic [15:0] tco, input logic [15:0] ti, input logic [15:0] tci,
                      input logic [9:0] ep, input logic [11:0] ev, input logic [15:0] et, input logic es);
      {req_valid, req_port, req_unicast, req_dest_known, req_dest_port} = {1'b1, p, u, k, d};
      {req_type_outer, req_tci_outer, req_type_inner, req_tci_inner} = {to, tco, ti, tci};
      @(posedge clk_sys);
      #1 req_valid = 0;
      chk(resp_valid, 0);
      @(posedge clk_sys);
      #1 chk(resp_valid, 1);
      @(posedge clk_sys);
      #1 chk(resp_valid, 0);
      chk({cap_ports, cap_discard}, {ep, ep == 0});
      chk({cap_vid, cap_tci}, {ev, et});
      chk({cap_stk, cap_learn}, {es, tag_mode});
   endtask

   // =========================================================================
   // Scenarios
   task automatic t_reset();
      logic [7:0] ra [11] = '{8'h00, 8'h01, 8'h12, 8'h13, 8'h20, 8'h40, 8'h41, 8'h42, 8'h43, 8'h48, 8'h50};
      logic [7:0] rv [11] = '{8'hfe, 8'h03, 8'hff, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h91, 8'h00, 8'h00};
      // map reset values and unmapped reads
      for (int i = 0; i < 11; i++) begin
         rd(ra[i], rv[i]);
      end
   endtask
   task automatic t_port();
      wr(8'h00, 8'h06);
      wr(8'h01, 8'h00);
      wr(8'h03, 8'hfe);
      rd(8'h03, 8'h02);
      req(0, 0, 0, 0, 16'h8100, 16'h0007, 16'h0800, 0, 10'h006, 12'h007, 16'h0007, 0);
      req(0, 1, 1, 1, 16'h0800, 0, 0, 0, 10'h002, 12'h001, 16'h0001, 0);
      req(0, 1, 1, 5, 16'h0800, 0, 0, 0, 10'h000, 12'h001, 16'h0001, 0);
      req(1, 0, 0, 0, 16'h0800, 0, 0, 0, 10'h2fd, 12'h001, 16'h0001, 0);
      wr(8'h04, 8'h00);
      wr(8'h05, 8'h00);
      req(2, 0, 0, 0, 16'h0800, 0, 0, 0, 10'h000, 12'h001, 16'h0001, 0);
      rd(8'h00, 8'h06);
      rd(8'h48, 8'h02);
   endtask
   task automatic t_tag();
      wr(8'h40, 8'h01);
      tag_mode = 1;
      wr(8'h44, 8'h05);
      wr(8'h45, 8'h00);
      wr(8'h46, 8'h0f);
      wr(8'h47, 8'h02);
      req(0, 0, 0, 0, 16'h8100, 16'h6005, 16'h0800, 0, 10'h20f, 12'h005, 16'h6005, 0);
      req(0, 1, 1, 2, 16'h8100, 16'h6005, 16'h0800, 0, 10'h004, 12'h005, 16'h6005, 0);
      req(0, 1, 1, 6, 16'h8100, 16'h0005, 16'h0800, 0, 10'h20f, 12'h005, 16'h0005, 0);
      req(0, 0, 0, 0, 16'h8100, 16'h0009, 16'h0800, 0, 10'h000, 12'h009, 16'h0009, 0);
   endtask
   task automatic t_stack();
      // provider tag with default and customer-valued TPID
      req(3, 0, 0, 0, 16'h9100, 16'h0003, 16'h8100, 16'h2005, 10'h20f, 12'h005, 16'h2005, 1);
      wr(8'h42, 8'h00);
      wr(8'h43, 8'h81);
      req(3, 0, 0, 0, 16'h8100, 16'h0005, 16'h8100, 16'h0009, 10'h20f, 12'h005, 16'h0005, 0);
      rd(8'h48, 8'h03);
   endtask
   task automatic t_private();
      // protected fast ports, port 8 never protected
      wr(8'h40, 8'h00);
      tag_mode = 0;
      wr(8'h41, 8'h03);
      rd(8'h41, 8'h03);
      // Untagged frames on port 1 take its default VLAN; unused high bits are dropped.
      wr(8'h22, 8'h34);
      wr(8'h23, 8'hfa);
      rd(8'h23, 8'h0a);
      req(1, 0, 0, 0, 16'h0800, 0, 0, 0, 10'h2fc, 12'ha34, 16'h0a34, 0);
      req(0, 0, 0, 0, 16'h0800, 0, 0, 0, 10'h004, 12'h001, 16'h0001, 0);
      req(8, 0, 0, 0, 16'h0800, 0, 0, 0, 10'h2ff, 12'h001, 16'h0001, 0);
   endtask

   // =========================================================================
   // Main sequence and watchdog
   initial begin
      repeat (16) @(posedge clk_sys);
      #1 reset_n = 1;
      @(posedge clk_sys);
      #1;
      t_reset();
      t_port();
      t_tag();
      t_stack();
      t_private();
      summarize();
   end
   // The full run is well under 400 cycles; the limit leaves ample margin.
   initial begin
      #20000;
      err_total++;
      summarize();
   end
endmodule
